// file: src/tmc_timer.sv
// Eight-bit timer/counter with shared prescaler and AXI4-Lite register slave
`timescale 1ns/1ps
`include "tmc_consts.svh"

// Contract
// RULE1: Eight-bit count register is read/writable; wrap from FFh to 00h sets overflow flag.
// RULE2: Clock source select clear gives timer mode, one step per instruction cycle.
// RULE3: A write to the count register blocks counting for two instruction cycles.
// RULE4: Clock source select set gives counter mode, stepping on input pin edges.
// RULE5: Edge select clear counts rising pin edges, set counts falling edges.
// RULE6: One prescaler serves counter or watchdog only; its count is not software visible.
// RULE7: Interrupt request passes only while overflow enable is set; flag unaffected.
// RULE8: Software clears the overflow flag; the hardware never clears it itself.
// RULE9: Counter halts during sleep, so overflow cannot wake the core.
// RULE10: Without prescaler the input goes straight to the prescaler output point.
// RULE11: Prescaler output is sampled on second and fourth phase clocks.
// RULE12: External source holds input high and low at least two oscillator periods.
// RULE13: Three-bit ratio: 1:2 to 1:256 for counter, 1:1 to 1:128 for watchdog.
// RULE14: With prescaler on counter, count writes clear prescaler, keep its assignment.
// RULE15: Prescaler assignment bit set picks watchdog, clear picks the counter.
module tmc_timer (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        counter_input_pin,
  input  wire logic        core_sleep,
  input  wire logic        watchdog_step,
  input  wire logic        watchdog_clear,
  output logic             watchdog_tick,
  output logic             irq
);

  tmc_pkg::tmc_state_type s_r;
  tmc_pkg::tmc_state_type s_nxt;

  // ==========================================================================
  // Shared wires
  logic       to_wd;
  logic       run;
  logic       src;
  logic       pre_step;
  logic       pre_clear;
  logic       pre_out;
  logic       count_bit;
  logic       wd_hit;
  logic [7:0] pre_count;
  logic       sample_now;
  logic       inc;
  logic       overflow;
  logic       do_wr;
  logic       wr_en;
  logic       cnt_wr;
  logic       opt_wr;
  logic       intc_wr;

  // Assignment and run conditions
  assign to_wd  = s_r.option[`TMC_OPT_ASSIGN]; // RULE15
  assign run    = !core_sleep; // RULE9

  // Count source: phase square wave in timer mode, edge-selected pin in counter mode
  assign src = s_r.option[`TMC_OPT_CS] ? (s_r.sync2 ^ s_r.option[`TMC_OPT_SE]) : !s_r.phase[1]; // RULE2 RULE4 RULE5

  // Prescaler is fed by the watchdog or by rising edges of the count source
  assign pre_step  = to_wd ? watchdog_step : (run && src && !s_r.src_prev); // RULE6
  assign pre_clear = to_wd ? watchdog_clear : cnt_wr; // RULE14

  // Prescaler bypassed when it serves the watchdog
  assign pre_out = to_wd ? src : count_bit; // RULE10

  // Sampling points on the second and fourth phase
  assign sample_now = (s_r.phase == `TMC_PH_Q2) || (s_r.phase == `TMC_PH_Q4); // RULE11

  // One step per rising edge seen at the sampling points, held off after a write
  assign inc = sample_now && pre_out && !s_r.samp && run && (s_r.inhibit == `TMC_INH_ZERO); // RULE3 RULE9

  // Register write decode
  assign do_wr    = s_r.aw_have && s_r.w_have;
  assign wr_en    = do_wr && s_r.w_strb[`TMC_STRB_LOW];
  assign cnt_wr   = wr_en && (s_r.aw_addr == `TMC_ADDR_COUNT);
  assign opt_wr   = wr_en && (s_r.aw_addr == `TMC_ADDR_OPTION);
  assign intc_wr  = wr_en && (s_r.aw_addr == `TMC_ADDR_INTCTL);
  assign overflow = inc && !cnt_wr && (s_r.count == `TMC_COUNT_MAX); // RULE1

  // ==========================================================================
  // Shared prescaler
  tmc_prescaler u_prescaler (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .step      (pre_step),
    .clear     (pre_clear),
    .ratio     (s_r.option[`TMC_OPT_PS_HI:0]),
    .to_wd     (to_wd),
    .count_bit (count_bit),
    .wd_hit    (wd_hit),
    .pre_count (pre_count)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;

    // Pin synchroniser and phase clock
    s_nxt.sync1    = counter_input_pin;
    s_nxt.sync2    = s_r.sync1;
    s_nxt.phase    = s_r.phase + `TMC_PH_ONE;
    s_nxt.src_prev = src;
    if (sample_now) begin
      s_nxt.samp = pre_out; // RULE11
    end

    // Write hold-off window
    if (cnt_wr) begin
      s_nxt.inhibit = `TMC_INH_CYC; // RULE3
    end else if (s_r.inhibit != `TMC_INH_ZERO) begin
      s_nxt.inhibit = s_r.inhibit - `TMC_INH_ONE;
    end

    // Count register
    if (cnt_wr) begin
      s_nxt.count = s_r.w_data[7:0]; // RULE1
    end else if (inc) begin
      s_nxt.count = s_r.count + `TMC_PRE_ONE; // RULE1 RULE2 RULE4
    end

    // Option register; the prescaler assignment only changes here
    if (opt_wr) begin
      s_nxt.option = s_r.w_data[7:0]; // RULE14
    end

    // Interrupt control: flag clears on a written one, an overflow sets it and wins
    if (intc_wr) begin
      s_nxt.intc = (s_r.w_data[7:0] & ~`TMC_FLAG_MASK) | (s_r.intc & `TMC_FLAG_MASK);
      if (s_r.w_data[`TMC_IC_FLAG]) begin
        s_nxt.intc[`TMC_IC_FLAG] = 1'b0; // RULE8
      end
    end
    if (overflow) begin
      s_nxt.intc[`TMC_IC_FLAG] = 1'b1; // RULE1
    end

    // Write address and data taken in either order
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (do_wr) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      if ((s_r.aw_addr == `TMC_ADDR_COUNT) || (s_r.aw_addr == `TMC_ADDR_OPTION) ||
          (s_r.aw_addr == `TMC_ADDR_INTCTL)) begin
        s_nxt.bresp = `TMC_RESP_OKAY;
      end else begin
        s_nxt.bresp = `TMC_RESP_SLVERR;
      end
    end

    // Read channel; the prescaler count is never on the read path
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = `TMC_RESP_OKAY;
      case (s_axi_araddr)
        `TMC_ADDR_COUNT: begin
          s_nxt.rdata = {24'h000000, s_r.count}; // RULE1
        end
        `TMC_ADDR_OPTION: begin
          s_nxt.rdata = {24'h000000, s_r.option};
        end
        `TMC_ADDR_INTCTL: begin
          s_nxt.rdata = {24'h000000, s_r.intc};
        end
        default: begin
          s_nxt.rdata = 32'h00000000; // RULE6
          s_nxt.rresp = `TMC_RESP_SLVERR;
        end
      endcase
    end

    // Registered ready strobes and outputs
    s_nxt.awready  = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready   = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready  = !s_nxt.rvalid;
    s_nxt.irq      = s_nxt.intc[`TMC_IC_FLAG] && s_nxt.intc[`TMC_IC_EN]; // RULE7
    s_nxt.wd_tick  = wd_hit; // RULE6
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r        <= '0;
      s_r.option <= `TMC_OPT_RESET;
      s_r.count  <= `TMC_COUNT_RESET;
      s_r.intc   <= `TMC_INTC_RESET;
      s_r.samp   <= `TMC_SAMP_RESET; // No false edge at the first sample point
    end else begin
      s_r <= s_nxt;
    end
  end

  // Ports straight from the state register
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;
  assign irq           = s_r.irq;
  assign watchdog_tick = s_r.wd_tick;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_wrap_sets_flag;
    overflow |=> (s_r.count == 8'h00) && s_r.intc[`TMC_IC_FLAG];
  endproperty
  a_wrap_sets_flag: assert property (p_wrap_sets_flag) // RULE1
    else $error("count wrap did not set overflow flag");

  property p_timer_rate;
    (!s_r.option[`TMC_OPT_CS] && to_wd && inc && !cnt_wr && !opt_wr) ##1
      (run && !cnt_wr && !opt_wr) [*3] ##1 run |-> inc;
  endproperty
  a_timer_rate: assert property (p_timer_rate) // RULE2
    else $error("timer mode missed an instruction cycle step");

  property p_write_holdoff;
    cnt_wr |=> !inc [*8];
  endproperty
  a_write_holdoff: assert property (p_write_holdoff) // RULE3
    else $error("count advanced inside write hold-off");

  property p_irq_gate;
    s_r.irq == (s_r.intc[`TMC_IC_FLAG] && s_r.intc[`TMC_IC_EN]);
  endproperty
  a_irq_gate: assert property (p_irq_gate) // RULE7
    else $error("interrupt output disagrees with flag and enable");

  property p_flag_sw_clear;
    $fell(s_r.intc[`TMC_IC_FLAG]) |-> $past(intc_wr && s_r.w_data[`TMC_IC_FLAG]);
  endproperty
  a_flag_sw_clear: assert property (p_flag_sw_clear) // RULE8
    else $error("overflow flag cleared without a software write");

  property p_sleep_hold;
    (core_sleep && !cnt_wr) |=> (s_r.count == $past(s_r.count));
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) // RULE9
    else $error("count changed during sleep");

  property p_sample_phase;
    inc |-> (s_r.phase == `TMC_PH_Q2) || (s_r.phase == `TMC_PH_Q4);
  endproperty
  a_sample_phase: assert property (p_sample_phase) // RULE11
    else $error("count stepped outside a sampling phase");

  property p_write_clears_pre;
    (cnt_wr && !to_wd) |=> (pre_count == 8'h00) && (to_wd == $past(to_wd));
  endproperty
  a_write_clears_pre: assert property (p_write_clears_pre) // RULE14
    else $error("count write left prescaler uncleared");

  property p_wd_only_assigned;
    s_r.wd_tick |-> $past(to_wd);
  endproperty
  a_wd_only_assigned: assert property (p_wd_only_assigned) // RULE6 RULE15
    else $error("watchdog tick while prescaler serves the counter");

  property p_flag_from_wrap;
    $rose(s_r.intc[`TMC_IC_FLAG]) |-> $past(overflow);
  endproperty
  a_flag_from_wrap: assert property (p_flag_from_wrap) // RULE1
    else $error("overflow flag set without a count wrap");

  property p_count_write_lands;
    cnt_wr |=> (s_r.count == $past(s_r.w_data[7:0]));
  endproperty
  a_count_write_lands: assert property (p_count_write_lands) // RULE1
    else $error("count write did not land");

  property p_counter_edge;
    (s_r.option[`TMC_OPT_CS] && to_wd && inc && (s_r.option == $past(s_r.option, 2))) |->
      (s_r.sync2 != s_r.option[`TMC_OPT_SE]) && ($past(s_r.sync2, 2) == s_r.option[`TMC_OPT_SE]);
  endproperty
  a_counter_edge: assert property (p_counter_edge) // RULE4 RULE5 RULE10
    else $error("counter mode step without a selected pin edge");

  property p_prescaled_edge;
    (!to_wd && inc && (s_r.option == $past(s_r.option, 2))) |-> count_bit && !$past(count_bit, 2);
  endproperty
  a_prescaled_edge: assert property (p_prescaled_edge) // RULE13
    else $error("prescaled step without a prescaler output edge");

  property p_pre_idle_on_wd;
    (to_wd && !watchdog_step && !watchdog_clear) |=> (pre_count == $past(pre_count));
  endproperty
  a_pre_idle_on_wd: assert property (p_pre_idle_on_wd) // RULE6
    else $error("counter side moved the prescaler while it serves the watchdog");

  property p_pre_idle_asleep;
    (!to_wd && core_sleep && !cnt_wr) |=> (pre_count == $past(pre_count));
  endproperty
  a_pre_idle_asleep: assert property (p_pre_idle_asleep) // RULE9
    else $error("prescaler stepped during sleep");

  property p_write_answer;
    do_wr |=> s_r.bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response missing after address and data");

  property p_read_answer;
    (s_axi_arvalid && s_r.arready) |=> s_r.rvalid && (s_r.rdata[31:8] == 24'h000000);
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read data missing or upper bits not zero");

endmodule // tmc_timer

// file: src/tmc_consts.svh
// Constants of the eight-bit timer/counter: offsets, fields, reset values, timing
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// ==========================================================================
// Register indices and byte addresses (byte address is four times the index)
`define TMC_IDX_COUNT    10'h001
`define TMC_IDX_OPTION   10'h081
`define TMC_IDX_INTCTL   10'h00B
`define TMC_ADDR_COUNT   {`TMC_IDX_COUNT, 2'h0}
`define TMC_ADDR_OPTION  {`TMC_IDX_OPTION, 2'h0}
`define TMC_ADDR_INTCTL  {`TMC_IDX_INTCTL, 2'h0}

// ==========================================================================
// Field positions
`define TMC_OPT_CS       5
`define TMC_OPT_SE       4
`define TMC_OPT_ASSIGN   3
`define TMC_OPT_PS_HI    2
`define TMC_IC_EN        5
`define TMC_IC_FLAG      2
`define TMC_STRB_LOW     0

// ==========================================================================
// Reset and limit values
`define TMC_OPT_RESET    8'hFF
`define TMC_COUNT_RESET  8'h00
`define TMC_INTC_RESET   8'h00
`define TMC_COUNT_MAX    8'hFF
`define TMC_FLAG_MASK    8'h04
`define TMC_PRE_ZERO     8'h00
`define TMC_PRE_ONE      8'h01
`define TMC_SAMP_RESET   1'b1

// ==========================================================================
// Timing: four phase clocks per instruction cycle, 10 ns aclk period
`define TMC_CLK_NS       10
`define TMC_QPH          4
`define TMC_INH_INSTR    2
`define TMC_INH_CYC      4'(`TMC_INH_INSTR * `TMC_QPH)
`define TMC_INH_ZERO     4'h0
`define TMC_INH_ONE      4'h1
`define TMC_PH_ONE       2'h1
`define TMC_PH_Q2        2'h1
`define TMC_PH_Q4        2'h3

// ==========================================================================
// Bus answers
`define TMC_RESP_OKAY    2'h0
`define TMC_RESP_SLVERR  2'h2

`endif

// file: src/tmc_pkg.sv
// Types of the eight-bit timer/counter
package tmc_pkg;

  // ==========================================================================
  // Prescaler state
  typedef struct packed {
    logic [7:0] cnt;
  } tmc_pre_state_type;

  // ==========================================================================
  // Timer/counter and bus slave state
  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic [1:0]  phase;
    logic        src_prev;
    logic        samp;
    logic [7:0]  count;
    logic [7:0]  option;
    logic [7:0]  intc;
    logic [3:0]  inhibit;
    logic        aw_have;
    logic [11:0] aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
    logic        wd_tick;
  } tmc_state_type;

endpackage

// file: src/tmc_prescaler.sv
// Shared prescaler serving either the timer/counter or the watchdog
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tmc_prescaler (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       step,
  input  wire logic       clear,
  input  wire logic [2:0] ratio,
  input  wire logic       to_wd,
  output logic            count_bit,
  output logic            wd_hit,
  output logic [7:0]      pre_count
);

  tmc_pkg::tmc_pre_state_type s_r;
  tmc_pkg::tmc_pre_state_type s_nxt;
  logic [7:0]                 wd_mask;

  // Count source steps; a clear wins over a step
  always_comb begin
    s_nxt = s_r;
    if (clear) begin
      s_nxt.cnt = `TMC_PRE_ZERO;
    end else if (step) begin
      s_nxt.cnt = s_r.cnt + `TMC_PRE_ONE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Counter side divides by 2^(ratio+1): bit ratio completes one period then
  assign count_bit = s_r.cnt[ratio]; // RULE13
  // Watchdog side divides by 2^ratio
  assign wd_mask   = (`TMC_PRE_ONE << ratio) - `TMC_PRE_ONE;
  assign wd_hit    = step && to_wd && ((s_r.cnt & wd_mask) == wd_mask); // RULE13
  assign pre_count = s_r.cnt;

endmodule // tmc_prescaler

// file: bench/tmc_pin_src.sv
// Behavioural pulse source driving the counter input pin
`timescale 1ns/1ps

module tmc_pin_src (
  input  wire logic       aclk,
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  input  wire logic [7:0] hi_cyc,
  input  wire logic [7:0] lo_cyc,
  output logic            pin,
  output logic            busy
);
  // ==========================================================================
  // Pulse train, high then low per pulse; the pin rests low between trains
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go === 1'b1) begin
        busy <= 1'b1;
        repeat (pulses) begin
          pin <= 1'b1;
          repeat ((hi_cyc < 8'h04) ? 8'h04 : hi_cyc) @(posedge aclk);
          pin <= 1'b0;
          repeat ((lo_cyc < 8'h04) ? 8'h04 : lo_cyc) @(posedge aclk);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // tmc_pin_src

// file: bench/tb_top.sv
// Self-checking testbench of the eight-bit timer/counter
`timescale 1ns/1ps
`include "tmc_consts.svh"

module tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic        arready, rvalid, pin, core_sleep, wd_step, wd_clr, tick, irq, go, busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd, keep;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [7:0]  pulses, hi_cyc, lo_cyc;
  int          fail_count = 0;
  int          total_checks = 0;
  int          wd_ticks = 0;
  int          t0;

  tmc_timer tmc_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .counter_input_pin(pin),
    .core_sleep(core_sleep), .watchdog_step(wd_step), .watchdog_clear(wd_clr),
    .watchdog_tick(tick), .irq(irq));
  tmc_pin_src tmc_pin_src_i (.aclk(aclk), .go(go), .pulses(pulses), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc),
    .pin(pin), .busy(busy));

  // ==========================================================================
  // Clock and watchdog tick tally
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) if (tick === 1'b1) wd_ticks <= wd_ticks + 1;

  // ==========================================================================
  // Report, compares and bounded waits
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    total_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      fail_count++;
      $display("unexpected at %0t: wait got %h expected below %h", $time, n, lim);
      end_sim();
    end
  endtask

  // ==========================================================================
  // AXI4-Lite master: payload held until each channel is taken
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int n;
    logic aw_p, w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while ((aw_p || w_p) && n < 200) begin
      @(posedge aclk);
      n++;
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 200);
    rsp = bresp;
    bready <= 1'b0;
    tmo(n, 200);
  endtask
  task automatic rd_reg(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 200);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
    tmo(n, 200);
  endtask

  // ==========================================================================
  // Pin source and watchdog pulse helpers
  task automatic start_src(input logic [7:0] n, input logic [7:0] h, input logic [7:0] l);
    @(posedge aclk);
    pulses <= n;
    hi_cyc <= h;
    lo_cyc <= l;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task automatic wait_src();
    int n;
    n = 0;
    repeat (2) @(posedge aclk);
    while (busy === 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    tmo(n, 2000);
    repeat (12) @(posedge aclk);
  endtask
  task automatic wdp(input logic clr);
    @(posedge aclk);
    if (clr) wd_clr <= 1'b1;
    else wd_step <= 1'b1;
    @(posedge aclk);
    wd_clr <= 1'b0;
    wd_step <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, core_sleep, wd_step, wd_clr, go} = '0;
    {awaddr, araddr, wdata, wstrb, pulses, hi_cyc, lo_cyc} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`TMC_ADDR_COUNT); chk(rd, 32'h00000000);
    rd_reg(`TMC_ADDR_OPTION); chk(rd, 32'h000000FF);
    rd_reg(`TMC_ADDR_INTCTL); chk(rd, 32'h00000000);
    wr(12'h100, 8'h55); chk(32'(rsp), 32'(`TMC_RESP_SLVERR));
    rd_reg(12'h100); chk(32'(rsp), 32'(`TMC_RESP_SLVERR));
    // Timer mode without prescaler, hold-off after a count write
    wr(`TMC_ADDR_OPTION, 8'h08);
    wr(`TMC_ADDR_COUNT, 8'h10);
    rd_reg(`TMC_ADDR_COUNT); chk(rd, 32'h00000010);
    repeat (40) @(posedge aclk);
    rd_reg(`TMC_ADDR_COUNT); chk_rng(rd, 32'h00000017, 32'h0000001B);
    // Prescaler on the timer, cleared by each count write
    for (int r = 0; r < 3; r++) begin
      wr(`TMC_ADDR_OPTION, 8'(r));
      wr(`TMC_ADDR_COUNT, 8'h00);
      repeat (200) @(posedge aclk);
      rd_reg(`TMC_ADDR_COUNT); chk_rng(rd, 32'(196 / (8 << r) - 1), 32'(196 / (8 << r) + 1));
    end
    // Sleep freezes the count and the prescaler serving it
    wr(`TMC_ADDR_OPTION, 8'h00);
    @(posedge aclk);
    core_sleep <= 1'b1;
    rd_reg(`TMC_ADDR_COUNT);
    keep = rd;
    repeat (40) @(posedge aclk);
    rd_reg(`TMC_ADDR_COUNT); chk(rd, keep);
    core_sleep <= 1'b0;
    // Overflow flag, masking and software clear
    wr(`TMC_ADDR_INTCTL, 8'h00);
    wr(`TMC_ADDR_COUNT, 8'hFE);
    repeat (40) @(posedge aclk);
    rd_reg(`TMC_ADDR_INTCTL); chk(rd, 32'h00000004);
    chk(32'(irq), 32'h00000000);
    wr(`TMC_ADDR_INTCTL, 8'h20);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h00000001);
    repeat (100) @(posedge aclk);
    rd_reg(`TMC_ADDR_INTCTL); chk(rd, 32'h00000024);
    wr(`TMC_ADDR_INTCTL, 8'h24);
    rd_reg(`TMC_ADDR_INTCTL); chk(rd, 32'h00000020);
    chk(32'(irq), 32'h00000000);
    // Counter mode, both edge selections, long high phase
    for (int se = 0; se < 2; se++) begin
      wr(`TMC_ADDR_OPTION, 8'h28 | 8'(se << 4));
      wr(`TMC_ADDR_COUNT, 8'h00);
      repeat (12) @(posedge aclk);
      start_src(8'h01, 8'h28, 8'h0A);
      repeat (20) @(posedge aclk);
      rd_reg(`TMC_ADDR_COUNT); chk(rd, 32'(1 - se));
      wait_src();
      rd_reg(`TMC_ADDR_COUNT); chk(rd, 32'h00000001);
    end
    // Counter mode through the prescaler at 1:2
    wr(`TMC_ADDR_OPTION, 8'h20);
    wr(`TMC_ADDR_COUNT, 8'h00);
    repeat (12) @(posedge aclk);
    start_src(8'h06, 8'h08, 8'h08);
    wait_src();
    rd_reg(`TMC_ADDR_COUNT); chk(rd, 32'h00000003);
    // Prescaler on the watchdog, cleared first
    for (int r = 0; r < 3; r++) begin
      wr(`TMC_ADDR_OPTION, 8'h28 | 8'(r));
      wdp(1'b1);
      t0 = wd_ticks;
      repeat (4) wdp(1'b0);
      repeat (4) @(posedge aclk);
      chk(32'(wd_ticks - t0), 32'(4 >> r));
    end
    end_sim();
  end
endmodule // tb_top
